// ==== hdl/ssp_port.sv ====
// Serial port core: shift register, receive buffer, flags and pin control
//
// How it works
// - Eight bits go out and eight come in per transfer, one each clock.
// - Data leaves and enters most significant bit first.
// - A full word lands in the buffer and sets buffer-full and irq.
// - Next byte may shift in while the previous byte waits unread.
// - Buffer write during a transfer is dropped and sets write collision.
// - Reading the data buffer clears buffer-full.
// - Shift register has no direct access; only the data buffer reaches it.
// - Enable hands data, clock and select pins to the port.
// - Data-in is an input only; the port has no direction control for it.
// - Master write to the buffer starts a transfer at once.
// - A master cannot be receive-only; data-out stays driven and each byte needs a buffer write.
// - Master rate is clock/4, /16, /64 or half the timer rate.
// - Polarity bit sets the idle level of the serial clock.
// - Edge select set puts valid data out before the first edge.
// - Sample-phase bit samples at middle or end of data time.
// - Slave shifts on external clock and sets irq at last bit.
// - Slave keeps working in sleep; a received byte raises wake.
// - Slave modes may use a select input as fourth line.
// - Mode codes 0..2 master div, 3 timer, 4 slave+select, 5 slave.
// - Select high floats data-out after the two synchroniser stages and zeroes the bit count.
// - Slave byte into a full buffer sets overflow and is lost.
`timescale 1ns/1ps
`include "ssp_defines.svh"
module ssp_port (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Configuration
  input wire ssp_pkg::ssp_cfg_s cfg,
  input wire logic timer_tick,
  // Data buffer access
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  input wire logic rd_stb,
  output logic [7:0] rd_data,
  // Flag clears from software
  input wire logic write_collision_flag_clr,
  input wire logic ovf_clr,
  input wire logic irq_clr,
  // Status
  output ssp_pkg::ssp_flags_s flags,
  output logic busy,
  output logic wake,
  // Serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic sel_b
);
  ssp_pkg::ssp_core_s s;
  ssp_pkg::ssp_core_s next_s;
  logic [1:0] pins_sync;
  logic half_tick;
  logic is_master;
  logic is_slave;
  logic sel_ctrl;
  logic sel_high;
  logic sck_now;
  logic run;
  logic edge_ev;
  logic [4:0] h;
  logic mid;
  logic smp_ev;
  logic shift_ev;
  logic done;
  logic last_smp;
  logic in_xfer;

  function automatic logic [7:0] shift_in(input logic [7:0] v,
                                          input logic b);
    shift_in = {v[6:0], b};
  endfunction

  // Pins come from another party, so they cross in before any edge logic
  ssp_sync u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in({sel_b, sck_i}),
    .sync_out(pins_sync)
  );

  ssp_rate_gen u_rate (
    .clock(clock),
    .rst_b(rst_b),
    .run(run),
    .rate_sel(cfg.mode_field[1:0]),
    .timer_tick(timer_tick),
    .half_tick(half_tick)
  );

  always_comb begin
    next_s = s;
    // Mode decode; other codes leave the port idle
    is_master = cfg.port_enable && (cfg.mode_field[3:2] == 2'b00);
    is_slave = cfg.port_enable &&
               (cfg.mode_field == `SSP_MODE_SLAVE_SEL ||
                cfg.mode_field == `SSP_MODE_SLAVE_NOSEL);
    sel_ctrl = cfg.mode_field == `SSP_MODE_SLAVE_SEL;
    sck_now = pins_sync[0];
    sel_high = pins_sync[1] && sel_ctrl;
    run = is_master && (s.state == ssp_pkg::SSP_RUN);
    in_xfer = (s.state == ssp_pkg::SSP_RUN) || (s.half_cnt != 5'h00);
    next_s.sck_prev = sck_now;
    next_s.wake = 1'b0;
    // Master steps on its own ticks, slave on external clock edges
    edge_ev = run ? half_tick
                  : (is_slave && !sel_high &&
                     (sck_now != s.sck_prev));
    h = s.half_cnt + 5'h01;
    // Odd edges leave idle; edge select decides which parity is mid-bit
    mid = cfg.clock_edge_sel ? h[0] : !h[0];
    smp_ev = cfg.sample_phase
             ? (!mid && h >= `SSP_FIRST_SHIFT_EDGE)
             : mid;
    shift_ev = !mid && h >= `SSP_FIRST_SHIFT_EDGE &&
               h < `SSP_LAST_CLOCK_EDGE;
    last_smp = edge_ev && smp_ev && (s.samples == `SSP_LAST_SAMPLE);
    // A master may only stop once its clock has made every edge
    done = is_master
           ? (edge_ev && h >= `SSP_LAST_CLOCK_EDGE &&
              (s.samples == `SSP_WORD_BITS || last_smp))
           : last_smp;

    // Clears first so a same-cycle set wins
    if (rd_stb) begin
      next_s.flags.buffer_full_flag = 1'b0;
    end
    if (write_collision_flag_clr) begin
      next_s.flags.write_collision_flag = 1'b0;
    end
    if (ovf_clr) begin
      next_s.flags.overflow_flag = 1'b0;
    end
    if (irq_clr) begin
      next_s.flags.port_irq_flag = 1'b0;
    end

    if (!is_master && !is_slave) begin
      // Disabled: transfer is dropped and counters forced to zero
      next_s.state = ssp_pkg::SSP_IDLE;
      next_s.half_cnt = 5'h00;
      next_s.samples = 4'h0;
      next_s.sck_level = 1'b0;
    end else if (sel_high) begin
      next_s.half_cnt = 5'h00;
      next_s.samples = 4'h0;
    end else if (edge_ev) begin
      next_s.half_cnt = h;
      if (is_master && h <= `SSP_LAST_CLOCK_EDGE) begin
        next_s.sck_level = !s.sck_level;
      end
      if (shift_ev) begin
        next_s.shift_reg = {s.shift_reg[6:0], 1'b0};
      end
      if (smp_ev) begin
        // Input shifts only on these edges, when data-out is driven as well
        next_s.rx_shift = shift_in(s.rx_shift, sdi);
        next_s.samples = s.samples + 4'h1;
      end
      if (done) begin
        next_s.state = ssp_pkg::SSP_IDLE;
        next_s.half_cnt = 5'h00;
        next_s.samples = 4'h0;
        next_s.sck_level = 1'b0;
        next_s.flags.port_irq_flag = 1'b1;
        next_s.wake = is_slave;
        if (is_slave && s.flags.buffer_full_flag) begin
          next_s.flags.overflow_flag = 1'b1;
        end else begin
          // Buffer is separate, so the next byte can start at once
          next_s.data_buffer = last_smp ? shift_in(s.rx_shift, sdi)
                                        : s.rx_shift;
          next_s.flags.buffer_full_flag = 1'b1;
        end
      end
    end

    // Software only ever reaches the shift register through this write
    if (wr_stb && (is_master || is_slave)) begin
      if (in_xfer) begin
        next_s.flags.write_collision_flag = 1'b1;
      end else begin
        next_s.shift_reg = wr_data;
        if (is_master) begin
          next_s.state = ssp_pkg::SSP_RUN;
          next_s.half_cnt = 5'h00;
          next_s.samples = 4'h0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data = s.data_buffer;
  assign flags = s.flags;
  assign busy = s.state == ssp_pkg::SSP_RUN || s.half_cnt != 5'h00;
  assign wake = s.wake;
  // Clock idles at the polarity level; pins handed over only when enabled
  assign sck_o = cfg.clock_idle_polarity ^ s.sck_level;
  assign sck_oe = is_master;
  assign sdo_o = s.shift_reg[7];
  // Data-in has no driver here, so it needs no direction control
  assign sdo_oe = is_master || (is_slave && !sel_high);
endmodule

// ==== hdl/ssp_defines.svh ====
// Constants of the serial port: mode codes, rates, counts and reset values
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

`define SSP_MODE_MASTER_DIV4 4'h0
`define SSP_MODE_MASTER_DIV16 4'h1
`define SSP_MODE_MASTER_DIV64 4'h2
`define SSP_MODE_MASTER_TIMER 4'h3
`define SSP_MODE_SLAVE_SEL 4'h4
`define SSP_MODE_SLAVE_NOSEL 4'h5

`define SSP_RATE_DIV4 2'h0
`define SSP_RATE_DIV16 2'h1
`define SSP_RATE_DIV64 2'h2
`define SSP_RATE_TIMER 2'h3

`define SSP_HALF_DIV4 6'h02
`define SSP_HALF_DIV16 6'h08
`define SSP_HALF_DIV64 6'h20

`define SSP_WORD_BITS 4'h8
`define SSP_LAST_SAMPLE 4'h7
`define SSP_FIRST_SHIFT_EDGE 5'h02
`define SSP_LAST_CLOCK_EDGE 5'h10

`define SSP_RESET_BYTE 8'h00

`endif

// ==== hdl/ssp_pkg.sv ====
// Types shared by the serial port modules
package ssp_pkg;

  typedef enum logic {SSP_IDLE, SSP_RUN} ssp_state_e;

  typedef struct packed {
    logic port_enable;
    logic clock_idle_polarity;
    logic clock_edge_sel;
    logic sample_phase;
    logic [3:0] mode_field;
  } ssp_cfg_s;

  typedef struct packed {
    logic buffer_full_flag;
    logic write_collision_flag;
    logic overflow_flag;
    logic port_irq_flag;
  } ssp_flags_s;

  typedef struct packed {
    logic [1:0] stage1;
    logic [1:0] stage2;
  } ssp_sync_s;

  typedef struct packed {
    logic [5:0] count;
    logic tick;
  } ssp_rate_s;

  typedef struct packed {
    ssp_state_e state;
    logic [7:0] shift_reg;
    logic [7:0] rx_shift;
    logic [7:0] data_buffer;
    logic [4:0] half_cnt;
    logic [3:0] samples;
    logic sck_level;
    logic sck_prev;
    logic wake;
    ssp_flags_s flags;
  } ssp_core_s;

endpackage

// ==== hdl/ssp_sync.sv ====
// Two-stage synchroniser for the serial clock and select inputs
`timescale 1ns/1ps
module ssp_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Asynchronous levels and their synchronised copies
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);
  ssp_pkg::ssp_sync_s s;
  ssp_pkg::ssp_sync_s next_s;

  // First stage feeds only the second stage
  always_comb begin
    next_s = s;
    next_s.stage1 = async_in;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stage2;
endmodule

// ==== hdl/ssp_rate_gen.sv ====
// Master bit-rate generator: one pulse per half serial clock period
`timescale 1ns/1ps
`include "ssp_defines.svh"
module ssp_rate_gen (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Control
  input wire logic run,
  input wire logic [1:0] rate_sel,
  input wire logic timer_tick,
  // Half-period pulse
  output logic half_tick
);
  ssp_pkg::ssp_rate_s s;
  ssp_pkg::ssp_rate_s next_s;

  function automatic logic [5:0] half_len(input logic [1:0] sel);
    case (sel)
      `SSP_RATE_DIV4: half_len = `SSP_HALF_DIV4;
      `SSP_RATE_DIV16: half_len = `SSP_HALF_DIV16;
      default: half_len = `SSP_HALF_DIV64;
    endcase
  endfunction

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.count = 6'h00;
    end else if (rate_sel == `SSP_RATE_TIMER) begin
      // Each timer pulse is half a bit, so the bit rate is timer rate / 2
      next_s.tick = timer_tick;
    end else if (s.count == half_len(rate_sel) - 6'h01) begin
      next_s.count = 6'h00;
      next_s.tick = 1'b1;
    end else begin
      next_s.count = s.count + 6'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign half_tick = s.tick;
endmodule

// ==== sim/ssp_peer.sv ====
// Far-side SPI device: slave to a master port, master to a slave port
`timescale 1ns/1ps
module ssp_peer (
  // Clock and mode
  input wire logic clock,
  input wire logic cpol,
  input wire logic cke,
  // Serial pins
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic sdo_o,
  output logic sck_i,
  output logic sdi,
  output logic sel_b,
  // Bytes sent and captured
  input wire logic [7:0] tx,
  output logic [7:0] got
);
  int p;
  initial begin
    sck_i = 1'b0;
    sdi = 1'b1;
    sel_b = 1'b1;
    got = 8'h00;
    p = 8;
  end
  task automatic arm;
    p = 0;
    sdi = tx[7];
  endtask
  // Slave role: sample on one edge kind, change on the other
  always @(sck_o) begin
    if (sck_oe === 1'b1) begin
      if ((sck_o != cpol) == cke) begin
        got = {got[6:0], sdo_o};
      end else begin
        if (cke) p++;
        sdi = (p < 8) ? tx[7 - p] : ~sdi;
        if (!cke) p++;
      end
    end
  end
  // Master role: clock stands still outside the frame
  task automatic mx(input int nb, input logic [7:0] b);
    repeat (4) @(posedge clock);
    sel_b <= 1'b0;
    for (int i = 7; i > 7 - nb; i--) begin
      sdi <= b[i];
      repeat (4) @(posedge clock);
      got = {got[6:0], sdo_o};
      sck_i <= 1'b1;
      repeat (4) @(posedge clock);
      sck_i <= 1'b0;
    end
    repeat (4) @(posedge clock);
    sdi <= ~sdi;
    sel_b <= 1'b1;
  endtask
endmodule

// ==== sim/ssp_port_sva.sv ====
// Checker of the serial port
`timescale 1ns/1ps
module ssp_port_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Watched ports
  input wire ssp_pkg::ssp_cfg_s cfg,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  input wire ssp_pkg::ssp_flags_s flags,
  input wire logic busy,
  input wire logic wake,
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic sel_b
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  logic on;
  logic mst;
  assign on = cfg.port_enable;
  assign mst = on && cfg.mode_field <= 4'h3;
  property p_write_collision_flag;
    on && wr_stb && busy |=> flags.write_collision_flag;
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("no collision");
  property p_start;
    mst && wr_stb && !busy |=> busy && sdo_o == $past(wr_data[7]);
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_done;
    mst && $fell(busy) |-> flags.buffer_full_flag && flags.port_irq_flag;
  endproperty
  a_done: assert property (p_done) else $error("flags not set");
  property p_idle;
    mst && !busy |-> sck_o == cfg.clock_idle_polarity;
  endproperty
  a_idle: assert property (p_idle) else $error("clock not idle");
  property p_oe;
    mst |-> sck_oe && sdo_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("pins not driven");
  property p_sel;
    (on && cfg.mode_field == 4'h4 && sel_b) [*3] |-> !sdo_oe;
  endproperty
  a_sel: assert property (p_sel) else $error("data out driven");
  property p_wake;
    wake |-> flags.port_irq_flag && !mst;
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
  property p_ovf;
    $rose(flags.overflow_flag) |-> !$past(mst);
  endproperty
  a_ovf: assert property (p_ovf) else $error("master overflow");
  c_done: cover property (mst && $fell(busy));
  c_wake: cover property (wake);
  c_ovf: cover property ($rose(flags.overflow_flag));
endmodule
bind ssp_port ssp_port_sva u_chk (.clock, .rst_b, .cfg, .wr_stb, .wr_data,
  .flags, .busy, .wake, .sck_o, .sck_oe, .sdo_o, .sdo_oe, .sel_b);

// ==== sim/test_sync_serial_spi_port.sv ====
// Self-checking bench of the serial port
`timescale 1ns/1ps
module test_sync_serial_spi_port;
  logic clock, rst_b, timer_tick, wr_stb, rd_stb, write_collision_flag_clr, ovf_clr;
  logic irq_clr, sck_o, sck_oe, sck_i, sdi, sdo_o, sdo_oe, sel_b;
  logic busy, wake;
  logic [7:0] wr_data, rd_data, got, ptx, q[$];
  logic [31:0] rnd;
  ssp_pkg::ssp_cfg_s cfg;
  ssp_pkg::ssp_flags_s flags;
  int fail_count, cmp_count, tc, n, h;
  ssp_port DUT (.clock, .rst_b, .cfg, .timer_tick, .wr_stb, .wr_data,
    .rd_stb, .rd_data, .write_collision_flag_clr, .ovf_clr, .irq_clr, .flags, .busy,
    .wake, .sck_i, .sck_o, .sck_oe, .sdi, .sdo_o, .sdo_oe, .sel_b);
  ssp_peer PEER (.clock, .cpol(cfg.clock_idle_polarity),
    .cke(cfg.clock_edge_sel), .sck_o, .sck_oe, .sdo_o, .sck_i, .sdi,
    .sel_b, .tx(ptx), .got);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Timer output: a half bit every third cycle
  always @(posedge clock) begin
    tc <= (tc == 2) ? 0 : tc + 1;
    timer_tick <= (tc == 2);
  end
  always @(posedge clock) begin
    if ($rose(flags.port_irq_flag)) begin
      check(rd_data, q.size() > 0 ? q.pop_front() : 8'hxx);
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Mode changes only while disabled, or the pins glitch
  task automatic setup(input logic [7:0] c);
    @(posedge clock) cfg <= {1'b0, c[6:0]};
    @(posedge clock) cfg <= {1'b1, c[6:0]};
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clock) {wr_stb, wr_data} <= {1'b1, d};
    @(posedge clock) wr_stb <= 1'b0;
  endtask
  task automatic ack(input logic rd);
    @(posedge clock) {rd_stb, irq_clr, write_collision_flag_clr, ovf_clr} <= {rd, 3'h7};
    @(posedge clock) {rd_stb, irq_clr, write_collision_flag_clr, ovf_clr} <= 4'h0;
    @(posedge clock);
  endtask
  task automatic wait_irq;
    for (n = 0; n < 2000 && flags.port_irq_flag !== 1'b1; n++)
      @(posedge clock);
    if (n == 2000) begin
      fail_count++;
      final_report();
    end
  endtask
  initial begin
    rst_b = 1'b0;
    cfg = '0;
    {timer_tick, wr_stb, rd_stb, write_collision_flag_clr, ovf_clr, irq_clr} = '0;
    wr_data = 8'h00;
    ptx = 8'h00;
    {tc, fail_count, cmp_count} = '0;
    rnd = 32'h4167_eff6;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    // Every master rate with random clock shape and bytes
    for (int m = 0; m < 4; m++) begin
      rnd = lfsr(rnd);
      h = (m == 3) ? 3 : 2 << (2 * m);
      setup({1'b0, rnd[2:0], m[3:0]});
      ptx = rnd[15:8];
      PEER.arm();
      q.push_back(rnd[15:8]);
      wr(rnd[23:16]);
      wr(8'h3c);
      @(posedge clock);
      check({7'h00, flags.write_collision_flag}, 8'h01);
      wait_irq();
      check({7'h00, n >= 16 * h - 4 && n <= 17 * h + 6}, 8'h01);
      check(got, rnd[23:16]);
      ack(1'b1);
      check({7'h00, flags.buffer_full_flag}, 8'h00);
    end
    // Slave with select line: byte, overflow, aborted byte, byte
    setup(8'h24);
    wr(8'h96);
    q.push_back(8'h5a);
    PEER.mx(8, 8'h5a);
    wait_irq();
    check(got, 8'h96);
    ack(1'b0);
    q.push_back(8'h5a);
    PEER.mx(8, 8'hc3);
    wait_irq();
    check({7'h00, flags.overflow_flag}, 8'h01);
    ack(1'b1);
    PEER.mx(3, 8'h00);
    q.push_back(8'he7);
    PEER.mx(8, 8'he7);
    wait_irq();
    check({7'h00, flags.buffer_full_flag}, 8'h01);
    ack(1'b1);
    final_report();
  end
endmodule
